// file: hw/hpm_memory.sv
`timescale 1ns/100ps
`include "hpm_regs.svh"
// hardened program memory: ecc block store, sweep check, fabric rom
module hpm_memory
  import hpm_pkg::*;
#(
  parameter int FAB_DEPTH = `HPM_FAB_DEPTH
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  hpm_fetch_if.dev                     fetch,
  input  wire logic                    load_we,
  input  wire logic [`HPM_WORD_AW-1:0] load_addr,
  input  wire logic [`HPM_DATA_W-1:0]  load_data,
  input  wire logic [`HPM_WORD_W-1:0]  load_flip,
  input  wire logic                    rec_we,
  input  wire logic [`HPM_FAB_AW-1:0]  rec_addr,
  input  wire hpm_instr_t              rec_data,
  input  wire logic                    scan_clk,
  input  wire logic                    scan_reset,
  output logic                         scan_error,
  output logic                         scan_complete
);

  // ************************************************************
  // ecc helpers
  // ************************************************************

  // place data in non-power-of-two slots, then check bits
  function automatic logic [`HPM_WORD_W-1:0] ecc_encode
  (
    input logic [`HPM_DATA_W-1:0] d
  );
    logic [`HPM_WORD_W-1:0] c;
    logic [`HPM_CHK_W-1:0]  s;
    int                     j;
    c = '0;
    s = '0;
    j = 0;
    for (int p = 1; p < `HPM_WORD_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        c[p] = d[j];
        j++;
      end
    end
    for (int p = 1; p < `HPM_WORD_W; p++)
    begin
      if (c[p])
        s = s ^ 7'(p);
    end
    for (int k = 0; k < `HPM_CHK_W; k++)
      c[1 << k] = s[k];
    c[0] = ^c[`HPM_WORD_W-1:1];
    return c;
  endfunction

  // {overall parity, position syndrome}
  function automatic logic [`HPM_CHK_W:0] ecc_syndrome
  (
    input logic [`HPM_WORD_W-1:0] c
  );
    logic [`HPM_CHK_W-1:0] s;
    s = '0;
    for (int p = 1; p < `HPM_WORD_W; p++)
    begin
      if (c[p])
        s = s ^ 7'(p);
    end
    return {^c, s};
  endfunction

  // pull data back out of the slots
  function automatic logic [`HPM_DATA_W-1:0] ecc_data
  (
    input logic [`HPM_WORD_W-1:0] c
  );
    logic [`HPM_DATA_W-1:0] d;
    int                     j;
    d = '0;
    j = 0;
    for (int p = 1; p < `HPM_WORD_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        d[j] = c[p];
        j++;
      end
    end
    return d;
  endfunction

  // ************************************************************
  // ecc store
  // ************************************************************
  logic [`HPM_WORD_W-1:0] mem [`HPM_ECC_DEPTH]; // stored codewords

  // flip mask lets a test plant single or double errors
  always_ff @(posedge clk)
  begin
    if (load_we)
    begin
      mem[load_addr] <= ecc_encode(load_data) ^ load_flip;
    end
  end

  // ************************************************************
  // fetch path
  // ************************************************************
  logic [`HPM_WORD_W-1:0] rd_word;    // raw codeword
  logic [`HPM_WORD_W-1:0] fix_word;   // corrected codeword
  logic [`HPM_DATA_W-1:0] rd_data;    // corrected data
  logic [`HPM_CHK_W:0]    rd_syn;     // syndrome of raw word
  logic [1:0]             lane;       // instruction within word
  logic                   err_single; // correctable
  logic                   err_double; // uncorrectable
  hpm_instr_t             ecc_instr;  // selected instruction
  hpm_instr_t             ecc_instr_r;
  hpm_instr_t             ecc_instr_nxt;
  logic                   serr_r;
  logic                   serr_nxt;
  logic                   derr_r;
  logic                   derr_nxt;
  logic                   sel_r;      // which store drove last fetch
  logic                   sel_nxt;
  hpm_instr_t             fab_instr;  // fabric rom output

  // a word's three lanes stand 512 apart; lane chooses the third
  assign rd_word = mem[fetch.address[`HPM_WORD_AW-1:0]];
  assign lane    = fetch.address[`HPM_LANE_MSB:`HPM_LANE_LSB];
  assign rd_syn  = ecc_syndrome(rd_word);

  // decode and correct one bit
  always_comb
  begin
    fix_word   = rd_word;
    err_single = 1'b0;
    err_double = 1'b0;
    if (rd_syn[`HPM_CHK_W])
    begin
      err_single = 1'b1;
      if (rd_syn[`HPM_CHK_W-1:0] < 7'(`HPM_WORD_W))
        fix_word[rd_syn[`HPM_CHK_W-1:0]] =
          ~rd_word[rd_syn[`HPM_CHK_W-1:0]];
    end
    else if (rd_syn[`HPM_CHK_W-1:0] != '0)
    begin
      err_double = 1'b1;
    end
    rd_data = ecc_data(fix_word);
    // lanes beyond the third read as zero
    case (lane)
      2'h0:    ecc_instr = rd_data[17:0];
      2'h1:    ecc_instr = rd_data[35:18];
      2'h2:    ecc_instr = rd_data[53:36];
      default: ecc_instr = '0;
    endcase
  end

  // next values of the fetch registers
  always_comb
  begin
    ecc_instr_nxt = ecc_instr_r;
    sel_nxt       = sel_r;
    serr_nxt      = 1'b0;
    derr_nxt      = 1'b0;
    if (fetch.fetch_en)
    begin
      sel_nxt = fetch.rom_select;
      if (!fetch.rom_select)
      begin
        ecc_instr_nxt = ecc_instr;
        serr_nxt = err_single;
        derr_nxt = err_double;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ecc_instr_r <= '0;
      sel_r       <= 1'b0;
      serr_r      <= 1'b0;
      derr_r      <= 1'b0;
    end
    else
    begin
      ecc_instr_r <= ecc_instr_nxt;
      sel_r       <= sel_nxt;
      serr_r      <= serr_nxt;
      derr_r      <= derr_nxt;
    end
  end

  // recovery code kept apart in fabric logic
  hpm_fabric_rom #(
    .DEPTH (FAB_DEPTH)
  ) u_fab (
    .clk         (clk),
    .rst_n       (rst_n),
    .address     (fetch.address),
    .enable      (fetch.fetch_en & fetch.rom_select),
    .instruction (fab_instr),
    .load_we     (rec_we),
    .load_addr   (rec_addr),
    .load_data   (rec_data)
  );

  assign fetch.instruction       = sel_r ? fab_instr : ecc_instr_r;
  assign fetch.single_error_flag = serr_r;
  assign fetch.double_error_flag = derr_r;

  // ************************************************************
  // background sweep
  // ************************************************************
  logic [`HPM_WORD_AW-1:0] scan_ptr_r;  // word under check
  logic [`HPM_WORD_AW-1:0] scan_ptr_nxt;
  logic                    scan_clk_r;  // previous sweep clock
  logic                    scan_err_r;  // sticky fault
  logic                    scan_err_nxt;
  logic                    scan_done_r; // one-cycle sweep end
  logic                    scan_done_nxt;
  logic [`HPM_CHK_W:0]     scan_syn;
  logic                    scan_step;

  // one word per rising sweep clock; sampled as a plain input
  assign scan_step = scan_clk & ~scan_clk_r;
  assign scan_syn  = ecc_syndrome(mem[scan_ptr_r]);

  always_comb
  begin
    scan_ptr_nxt  = scan_ptr_r;
    scan_err_nxt  = scan_err_r;
    scan_done_nxt = 1'b0;
    if (scan_reset)
    begin
      scan_ptr_nxt = '0;
      scan_err_nxt = 1'b0;
    end
    else if (scan_step)
    begin
      if (scan_syn != '0)
        scan_err_nxt = 1'b1;
      scan_ptr_nxt = scan_ptr_r + 1'b1;
      if (scan_ptr_r == `HPM_WORD_AW'(`HPM_ECC_DEPTH - 1))
        scan_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_ptr_r  <= '0;
      scan_clk_r  <= 1'b0;
      scan_err_r  <= 1'b0;
      scan_done_r <= 1'b0;
    end
    else
    begin
      scan_ptr_r  <= scan_ptr_nxt;
      scan_clk_r  <= scan_clk;
      scan_err_r  <= scan_err_nxt;
      scan_done_r <= scan_done_nxt;
    end
  end

  assign scan_error    = scan_err_r;
  assign scan_complete = scan_done_r;
endmodule

// file: hw/hpm_regs.svh
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// ************************************************************
// fetch port geometry
// ************************************************************
`define HPM_ADDR_W      12
`define HPM_INSTR_W     18
`define HPM_WORD_W      72
`define HPM_DATA_W      64
`define HPM_CHK_W       7
`define HPM_WORD_AW     9
`define HPM_LANE_LSB    9
`define HPM_LANE_MSB    10
`define HPM_NUM_LANES   3
`define HPM_ECC_DEPTH   512
`define HPM_FAB_DEPTH   256
`define HPM_FAB_AW      8

// ************************************************************
// processor side constants
// ************************************************************
`define HPM_RESET_VEC   12'h000
`define HPM_RECOV_VEC   12'h000
`define HPM_HALT_INSTR  18'h3ffff

// ************************************************************
// controller register map (word offsets)
// ************************************************************
`define HPM_REG_AW      4
`define HPM_REG_CTRL    4'h0
`define HPM_REG_STATUS  4'h1
`define HPM_REG_MASK    4'h2
`define HPM_REG_PC      4'h3
`define HPM_REG_INSTR   4'h4

// ctrl bits
`define HPM_CTRL_RUN    0
`define HPM_CTRL_IEN    1
// status / mask bits
`define HPM_ST_W        4
`define HPM_ST_SERR     0
`define HPM_ST_DERR     1
`define HPM_ST_RECOV    2
`define HPM_ST_HALT     3
`endif

// file: hw/hpm_pkg.sv
package hpm_pkg;
  // instruction address and word
  typedef logic [11:0] hpm_addr_t;
  typedef logic [17:0] hpm_instr_t;
  // processor sequencer states, gray along idle-fetch-exec-halt
  typedef enum logic [1:0]
  {
    HPM_IDLE  = 2'h0,
    HPM_FETCH = 2'h1,
    HPM_EXEC  = 2'h3,
    HPM_HALT  = 2'h2
  } hpm_state_t;
endpackage

// file: hw/hpm_fetch_if.sv
`timescale 1ns/100ps
// fetch port between processor and program memory
interface hpm_fetch_if;
  import hpm_pkg::*;
  hpm_addr_t  address;            // instruction address
  logic       fetch_en;           // fetch strobe
  logic       rom_select;         // 1: recovery fabric rom
  hpm_instr_t instruction;        // registered instruction
  logic       single_error_flag;  // corrected error pulse
  logic       double_error_flag;  // uncorrectable error pulse

  modport dev
  (
    input  address,
    input  fetch_en,
    input  rom_select,
    output instruction,
    output single_error_flag,
    output double_error_flag
  );
  modport proc
  (
    output address,
    output fetch_en,
    output rom_select,
    input  instruction,
    input  single_error_flag,
    input  double_error_flag
  );
endinterface

// file: hw/hpm_fabric_rom.sv
`timescale 1ns/100ps
`include "hpm_regs.svh"
// small fabric-logic rom holding recovery code
module hpm_fabric_rom
  import hpm_pkg::*;
#(
  parameter int DEPTH = `HPM_FAB_DEPTH
)
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`HPM_ADDR_W-1:0] address,
  input  wire logic                  enable,
  output hpm_instr_t                 instruction,
  input  wire logic                  load_we,
  input  wire logic [`HPM_FAB_AW-1:0] load_addr,
  input  wire hpm_instr_t            load_data
);
  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // storage
  // ************************************************************
  hpm_instr_t mem [DEPTH];        // contents, loaded before use
  hpm_instr_t instr_r;            // output register
  hpm_instr_t instr_nxt;

  // contents are fixed in use; load port only fills them
  always_ff @(posedge clk)
  begin
    if (load_we)
    begin
      mem[load_addr[AW-1:0]] <= load_data;
    end
  end

  always_comb
  begin
    instr_nxt = instr_r;
    if (enable)
    begin
      instr_nxt = mem[address[AW-1:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      instr_r <= '0;
    else
      instr_r <= instr_nxt;
  end

  assign instruction = instr_r;
endmodule

// file: hw/hpm_processor.sv
`timescale 1ns/100ps
`include "hpm_regs.svh"
// processor stand-in: fetch sequencer with error interrupt
module hpm_processor
  import hpm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  hpm_fetch_if.proc                   fetch,
  input  wire logic [`HPM_REG_AW-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic [31:0]                 reg_rdata,
  output logic                        irq
);

  // ************************************************************
  // state
  // ************************************************************
  hpm_state_t            st_r;       // sequencer state
  hpm_state_t            st_nxt;
  hpm_addr_t             pc_r;       // program counter
  hpm_addr_t             pc_nxt;
  logic                  rsel_r;     // running from recovery rom
  logic                  rsel_nxt;
  logic                  run_r;      // software run enable
  logic                  run_nxt;
  logic                  ien_r;      // interrupt enable
  logic                  ien_nxt;
  logic [`HPM_ST_W-1:0]  stat_r;     // sticky events
  logic [`HPM_ST_W-1:0]  stat_nxt;
  logic [`HPM_ST_W-1:0]  mask_r;     // interrupt mask
  logic [`HPM_ST_W-1:0]  mask_nxt;
  logic [`HPM_ST_W-1:0]  ev;         // events this cycle
  hpm_instr_t            last_r;     // last executed instruction
  hpm_instr_t            last_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    st_nxt   = st_r;
    pc_nxt   = pc_r;
    rsel_nxt = rsel_r;
    last_nxt = last_r;
    ev       = '0;
    ien_nxt  = ien_r;
    if (reg_we && reg_addr == `HPM_REG_CTRL)
      ien_nxt = reg_wdata[`HPM_CTRL_IEN];
    unique case (st_r)
      HPM_IDLE:
      begin
        if (run_r)
          st_nxt = HPM_FETCH;
      end
      HPM_FETCH:
        st_nxt = HPM_EXEC;
      HPM_EXEC:
      begin
        last_nxt = fetch.instruction;
        ev[`HPM_ST_SERR] = fetch.single_error_flag;
        ev[`HPM_ST_DERR] = fetch.double_error_flag;
        st_nxt = run_r ? HPM_FETCH : HPM_IDLE;
        pc_nxt = pc_r + 1'b1;
        if (fetch.double_error_flag && ien_r && !rsel_r)
        begin
          pc_nxt   = `HPM_RECOV_VEC;
          rsel_nxt = 1'b1;
          ien_nxt  = 1'b0;
          ev[`HPM_ST_RECOV] = 1'b1;
        end
        else if (rsel_r && fetch.instruction == `HPM_HALT_INSTR)
        begin
          // no return path; stop for good
          st_nxt = HPM_HALT;
          ev[`HPM_ST_HALT] = 1'b1;
        end
      end
      HPM_HALT:
        st_nxt = HPM_HALT;
    endcase
  end

  // ************************************************************
  // registers for software
  // ************************************************************
  always_comb
  begin
    run_nxt  = run_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    // clear on read, new events win
    if (reg_re && reg_addr == `HPM_REG_STATUS)
      stat_nxt = '0;
    stat_nxt = stat_nxt | ev;
    if (reg_we)
    begin
      if (reg_addr == `HPM_REG_CTRL)
        run_nxt = reg_wdata[`HPM_CTRL_RUN];
      if (reg_addr == `HPM_REG_MASK)
        mask_nxt = reg_wdata[`HPM_ST_W-1:0];
    end
    // read data stands one cycle after the strobe only
    rdata_nxt = '0;
    if (reg_re)
    begin
      case (reg_addr)
        `HPM_REG_CTRL:   rdata_nxt = {30'h0, ien_r, run_r};
        `HPM_REG_STATUS: rdata_nxt = {28'h0, stat_r};
        `HPM_REG_MASK:   rdata_nxt = {28'h0, mask_r};
        `HPM_REG_PC:     rdata_nxt = {19'h0, rsel_r, pc_r};
        `HPM_REG_INSTR:  rdata_nxt = {14'h0, last_r};
        default:         rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r    <= HPM_IDLE;
      pc_r    <= `HPM_RESET_VEC;
      rsel_r  <= 1'b0;
      run_r   <= 1'b0;
      ien_r   <= 1'b0;
      stat_r  <= '0;
      mask_r  <= '0;
      last_r  <= '0;
      rdata_r <= '0;
    end
    else
    begin
      st_r    <= st_nxt;
      pc_r    <= pc_nxt;
      rsel_r  <= rsel_nxt;
      run_r   <= run_nxt;
      ien_r   <= ien_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      last_r  <= last_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // 12-bit address, strobe one cycle per fetch
  assign fetch.address    = pc_r;
  assign fetch.fetch_en   = (st_r == HPM_FETCH);
  // main program from ecc store until redirected
  assign fetch.rom_select = rsel_r;
  assign reg_rdata        = rdata_r;
  assign irq              = |(stat_r & mask_r);
endmodule

// file: bench/hpm_link_monitor.sv
`timescale 1ns/100ps
// ************************************************************
// fetch link watcher, sees both ends from outside
// ************************************************************
module hpm_link_monitor
  import hpm_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire hpm_addr_t  address,
  input wire logic       fetch_en,
  input wire logic       rom_select,
  input wire hpm_instr_t instruction,
  input wire logic       single_error_flag,
  input wire logic       double_error_flag
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  instr_hold_a: assert property (!fetch_en |=> $stable(instruction))
    else $error("instruction moved without a strobe");
  fetch_gap_a: assert property (fetch_en |=> !fetch_en)
    else $error("fetch strobes back to back");
  serr_cause_a: assert property (
    single_error_flag |-> $past(fetch_en) && !$past(rom_select))
    else $error("single error flag without main fetch");
  serr_pulse_a: assert property (
    single_error_flag |=> !single_error_flag)
    else $error("single error flag longer than a cycle");
  derr_cause_a: assert property (
    double_error_flag |-> $past(fetch_en) && !$past(rom_select))
    else $error("double error flag without main fetch");
  flag_excl_a: assert property (
    !(single_error_flag && double_error_flag))
    else $error("both error flags at once");
  redirect_entry_a: assert property (
    $rose(rom_select) |-> $past(double_error_flag) && address == 12'h000)
    else $error("recovery entered without double error");
  recov_stay_a: assert property (rom_select |=> rom_select)
    else $error("left recovery rom");

  // main scenarios reached
  cover property (single_error_flag);
  cover property (double_error_flag);
  cover property ($rose(rom_select));
endmodule

// file: bench/hpm_tb_top.sv
`timescale 1ns/100ps
`include "hpm_regs.svh"
// ************************************************************
// bench: processor end and memory end joined by the link
// ************************************************************
module hpm_tb_top
  import hpm_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_we = 1'h0;
  logic        reg_re = 1'h0;
  logic        irq;
  logic        load_we = 1'h0;
  logic [8:0]  load_addr = 9'h000;
  logic [63:0] load_data = 64'h0;
  logic [71:0] load_flip = 72'h0;
  logic        rec_we = 1'h0;
  logic [7:0]  rec_addr = 8'h00;
  hpm_instr_t  rec_data = 18'h00000;
  logic        scan_clk = 1'h0;
  logic        scan_reset = 1'h0;
  logic        scan_error;
  logic        scan_complete;
  // reference model of both stores and injected flips
  logic [17:0] mm [0:1535];
  logic [17:0] rm [0:255];
  logic [71:0] fl [0:511];
  logic [15:0] lf = 16'h0670;   // random source state
  int          err_count = 0;
  int          n_checks = 0;
  int          i, j, k, nf, n;
  logic        pend = 1'h0;      // a fetch awaits its answer
  logic        ps, sc_seen = 1'h0;
  int          n_rise = 0;       // sweep clock rises seen by the store
  logic        sc_prev = 1'h0;   // sweep clock at the previous edge
  hpm_addr_t   pa;

  hpm_fetch_if fif();
  hpm_memory u_hpm_memory (.clk(clk), .rst_n(rst_n), .fetch(fif),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .load_flip(load_flip), .rec_we(rec_we), .rec_addr(rec_addr),
    .rec_data(rec_data), .scan_clk(scan_clk), .scan_reset(scan_reset),
    .scan_error(scan_error), .scan_complete(scan_complete));
  hpm_processor u_hpm_processor (.clk(clk), .rst_n(rst_n), .fetch(fif),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));
  hpm_link_monitor u_hpm_link_monitor (.clk(clk), .rst_n(rst_n),
    .address(fif.address), .fetch_en(fif.fetch_en),
    .rom_select(fif.rom_select), .instruction(fif.instruction),
    .single_error_flag(fif.single_error_flag),
    .double_error_flag(fif.double_error_flag));

  always #25 clk = ~clk;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a bound that ran out ends the run
  task tmo;
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    give_verdict;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'h1;
    @(posedge clk);
    reg_we <= 1'h0;
  endtask

  // data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'h1;
    @(posedge clk);
    reg_re <= 1'h0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask

  // ************************************************************
  // fetch watcher: every answer against the model
  // ************************************************************
  always @(posedge clk)
  begin
    if (pend && rst_n)
    begin
      k = $countones(fl[pa[8:0]]);
      // a double error leaves the data unknown
      if (ps || k < 2)
        chk(fif.instruction, ps ? rm[pa[7:0]] : mm[pa]);
      chk(fif.single_error_flag, !ps && k == 1);
      chk(fif.double_error_flag, !ps && k == 2);
    end
    pend = rst_n && fif.fetch_en;
    pa = fif.address;
    ps = fif.rom_select;
    if (pend)
      nf++;
    // one word checked per sampled rise
    if (scan_complete === 1'h1 && !sc_seen)
      chk(n_rise, `HPM_ECC_DEPTH);
    if (scan_complete === 1'h1)
      sc_seen = 1'h1;
    if (rst_n && scan_reset !== 1'h1 && scan_clk && !sc_prev)
      n_rise++;
    sc_prev = scan_clk;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    nf = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    // fill all words, flips on 5 and 9 single, 20 double
    for (i = 0; i < 512; i++)
    begin
      for (j = 0; j < 3; j++)
      begin
        lf = nx(lf);
        mm[j * 512 + i] = {lf[1:0], lf};
      end
      lf = nx(lf);
      fl[i] = (i == 5 || i == 9) ? 72'h1 << (lf % 72) :
              (i == 20) ? 72'h3 << (lf % 70) : 72'h0;
      @(posedge clk);
      load_we <= 1'h1;
      load_addr <= i[8:0];
      load_data <= {10'h000, mm[1024 + i], mm[512 + i], mm[i]};
      load_flip <= fl[i];
    end
    @(posedge clk);
    load_we <= 1'h0;
    // recovery code: a few steps, then the stop word
    for (i = 0; i < 8; i++)
    begin
      lf = nx(lf);
      rm[i] = (i == 4) ? `HPM_HALT_INSTR : {1'h0, lf[0], lf};
      @(posedge clk);
      rec_we <= 1'h1;
      rec_addr <= i[7:0];
      rec_data <= rm[i];
    end
    @(posedge clk);
    rec_we <= 1'h0;
    for (i = 0; i < 3000 && !sc_seen; i++)
    begin
      @(posedge clk);
      if (i % 2 == 0)
        scan_clk <= ~scan_clk;
    end
    if (!sc_seen)
      tmo;
    chk(scan_error, 1'h1);
    scan_reset <= 1'h1;
    repeat (2) @(posedge clk);
    scan_reset <= 1'h0;
    @(posedge clk);
    chk(scan_error, 1'h0);
    // interrupts off: errors reported, no redirect
    wr(`HPM_REG_CTRL, 32'h1);
    repeat (80) @(posedge clk);
    wr(`HPM_REG_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    chk(fif.rom_select, 1'h0);
    rd(`HPM_REG_STATUS, 32'h3);
    rd(`HPM_REG_STATUS, 32'h0);
    // interrupts on: redirect into recovery, then stop
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    wr(`HPM_REG_CTRL, 32'h3);
    for (i = 0; i < 300 && fif.rom_select !== 1'h1; i++)
      @(posedge clk);
    if (i == 300)
      tmo;
    repeat (40) @(posedge clk);
    n = nf;
    repeat (20) @(posedge clk);
    chk(nf, n);
    wr(`HPM_REG_MASK, 32'h4);
    @(posedge clk);
    chk(irq, 1'h1);
    rd(`HPM_REG_STATUS, 32'hf);
    chk(irq, 1'h0);
    rd(`HPM_REG_STATUS, 32'h0);
    rd(4'h7, 32'h0);
    rd(`HPM_REG_CTRL, 32'h1);
    rd(`HPM_REG_INSTR, `HPM_HALT_INSTR);
    give_verdict;
  end
endmodule
